//--- include/iad_pkg.sv
// Package for the indirect address decoder: regions, layout constants and carriers.
package iad_pkg;

   // ***************************************************************
   // Address space layout
   // ***************************************************************
   localparam int PTR_W = 16;
   localparam logic [15:0] BANKED_END = 16'h1fff;
   localparam logic [15:0] LINEAR_BASE = 16'h2000;
   localparam logic [15:0] LINEAR_END = 16'h2fef;
   localparam int FLASH_BIT = 15;
   localparam int FLASH_AW = 15;
   localparam int DATA_AW = 13;
   localparam int BANK_SHIFT = 7;
   localparam logic [6:0] GPR_START = 7'h20;
   localparam logic [6:0] GPR_BYTES = 7'h50;
   localparam logic [6:0] PORT0_ADDR = 7'h00;
   localparam logic [6:0] PORT1_ADDR = 7'h01;
   localparam int NUM_PORTS = 2;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam int FLASH_EXTRA_CYCLES = 1;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      IAD_IDLE = 2'b00,
      IAD_WAIT = 2'b01
   } iad_state_e;

   typedef enum logic [1:0] {
      IAD_RGN_BANKED = 2'h0,
      IAD_RGN_LINEAR = 2'h1,
      IAD_RGN_FLASH = 2'h2,
      IAD_RGN_NONE = 2'h3
   } iad_region_e;

   // Core request: pointer bytes and access kind.
   typedef struct packed {
      logic [7:0] high_byte;
      logic [7:0] low_byte;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } iad_req_s;

   // Memory-side strobe group.
   typedef struct packed {
      logic data_rd;
      logic data_wr;
      logic [12:0] data_addr;
      logic [7:0] data_wdata;
      logic flash_rd;
      logic [14:0] flash_addr;
   } iad_mem_s;

endpackage : iad_pkg

//--- verilog/iad_decoder.sv
// Indirect address decoder between core execution and data/flash arrays.

// Function
// - Indirect port access redirects to pointer target.
// - Pointer at port itself: read zero, no write.
// - Pointer is high byte concatenated with low.
// - Banked region maps to absolute addresses.
// - Linear region maps onto 80-byte GENERAL_PURPOSE_RAM blocks.
// - Linear stepping crosses banks without gaps.
// - Unimplemented linear locations read as zero.
// - Common RAM excluded from linear mapping.
// - Top bit set selects 15-bit flash address.
// - Flash read returns low eight bits.
// - Flash writes have no effect.
// - Flash access takes one extra cycle.
module iad_decoder #(
   parameter int NUM_BANKS = 64,
   parameter int IMPL_BANKS = 2
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Core request side; req.rd/wr are one-cycle pulses.
   input wire iad_pkg::iad_req_s req,
   output logic done,
   output logic [7:0] rdata,
   output logic stall,
   // Memory side.
   output iad_pkg::iad_mem_s mem,
   input wire logic [7:0] data_rdata,
   input wire logic [13:0] flash_rdata
);

   // ***************************************************************
   // Decode
   // ***************************************************************
   logic [15:0] ptr;
   logic [15:0] lin_off;
   logic [6:0] lin_bank;
   logic [6:0] lin_rem;
   logic [12:0] data_addr;
   iad_pkg::iad_region_e region;
   logic is_port;
   logic lin_impl;
   iad_pkg::iad_state_e state_r;
   logic [7:0] flash_byte_r;
   logic flash_pend_r;
   logic data_pend_r;
   logic zero_pend_r;

   // Pointer assembly and linear translation.
   always_comb
   begin
      ptr = {req.high_byte, req.low_byte};
      lin_off = ptr - iad_pkg::LINEAR_BASE;
      lin_bank = 7'(lin_off / 16'(iad_pkg::GPR_BYTES));
      lin_rem = 7'(lin_off % 16'(iad_pkg::GPR_BYTES));
      lin_impl = (32'(lin_bank) < IMPL_BANKS);
      // Remainder lands at GENERAL_PURPOSE_RAM start, so common RAM is never reached.
      data_addr = {6'(lin_bank), 7'(lin_rem + iad_pkg::GPR_START)};
      is_port = 1'b0;
      if (ptr[iad_pkg::FLASH_BIT])
      begin
         region = iad_pkg::IAD_RGN_FLASH;
      end
      else if (ptr <= iad_pkg::BANKED_END)
      begin
         region = iad_pkg::IAD_RGN_BANKED;
         data_addr = ptr[12:0];
         is_port = (ptr[6:0] == iad_pkg::PORT0_ADDR) || (ptr[6:0] == iad_pkg::PORT1_ADDR);
      end
      else if (ptr <= iad_pkg::LINEAR_END && lin_impl)
      begin
         region = iad_pkg::IAD_RGN_LINEAR;
      end
      else
      begin
         region = iad_pkg::IAD_RGN_NONE;
      end
   end

   // ***************************************************************
   // Access sequencing
   // ***************************************************************
   // Memory strobes; writes to flash or unmapped space never strobe.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mem <= '0;
      end
      else
      begin
         mem.data_rd <= req.rd && !is_port && state_r == iad_pkg::IAD_IDLE
            && (region == iad_pkg::IAD_RGN_BANKED || region == iad_pkg::IAD_RGN_LINEAR);
         mem.data_wr <= req.wr && !is_port && state_r == iad_pkg::IAD_IDLE
            && (region == iad_pkg::IAD_RGN_BANKED || region == iad_pkg::IAD_RGN_LINEAR);
         mem.data_addr <= data_addr;
         mem.data_wdata <= req.wdata;
         mem.flash_rd <= req.rd && state_r == iad_pkg::IAD_IDLE
            && region == iad_pkg::IAD_RGN_FLASH;
         mem.flash_addr <= ptr[14:0];
      end
   end

   // Flash accesses hold an extra cycle in the wait state.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state_r <= iad_pkg::IAD_IDLE;
      else
         unique case (state_r)
            iad_pkg::IAD_IDLE:
               if ((req.rd || req.wr) && region == iad_pkg::IAD_RGN_FLASH)
                  state_r <= iad_pkg::IAD_WAIT;
            iad_pkg::IAD_WAIT:
               state_r <= iad_pkg::IAD_IDLE;
            default:
               state_r <= iad_pkg::IAD_IDLE;
         endcase
   end

   // Pending markers for data reads and writes, zero answers and flash answers.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         data_pend_r <= 1'b0;
         zero_pend_r <= 1'b0;
         flash_pend_r <= 1'b0;
         flash_byte_r <= iad_pkg::ZERO_BYTE;
      end
      else
      begin
         // The flash byte is caught in the wait cycle and answered one cycle later.
         flash_pend_r <= (state_r == iad_pkg::IAD_WAIT);
         if (state_r == iad_pkg::IAD_WAIT)
            flash_byte_r <= flash_rdata[7:0];
         data_pend_r <= (req.rd || req.wr) && state_r == iad_pkg::IAD_IDLE
            && !is_port && region != iad_pkg::IAD_RGN_FLASH
            && region != iad_pkg::IAD_RGN_NONE;
         zero_pend_r <= (req.rd || req.wr) && state_r == iad_pkg::IAD_IDLE
            && (is_port || region == iad_pkg::IAD_RGN_NONE);
      end
   end

   // Answer: data two cycles after request, flash three cycles after.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         done <= 1'b0;
         rdata <= iad_pkg::ZERO_BYTE;
         stall <= 1'b0;
      end
      else
      begin
         done <= data_pend_r || zero_pend_r || flash_pend_r;
         stall <= (req.rd || req.wr) && state_r == iad_pkg::IAD_IDLE
            && region == iad_pkg::IAD_RGN_FLASH;
         if (flash_pend_r)
            rdata <= flash_byte_r;
         else if (data_pend_r)
            rdata <= data_rdata;
         else
            rdata <= iad_pkg::ZERO_BYTE;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_port_no_write;
      @(posedge clk) disable iff (!rst_n)
      (req.wr && is_port) |=> !mem.data_wr;
   endproperty
   a_port_no_write: assert property (p_port_no_write) else $error("Port write leaked.");

   property p_flash_no_write;
      @(posedge clk) disable iff (!rst_n)
      (req.wr && ptr[15]) |=> !mem.data_wr;
   endproperty
   a_flash_no_write: assert property (p_flash_no_write) else $error("Flash write leaked.");

   property p_flash_extra;
      @(posedge clk) disable iff (!rst_n)
      (req.rd && ptr[15] && state_r == iad_pkg::IAD_IDLE) |=> !done ##1 !done ##1 done;
   endproperty
   a_flash_extra: assert property (p_flash_extra) else $error("Flash timing wrong.");

   property p_banked_addr;
      @(posedge clk) disable iff (!rst_n)
      (req.rd && ptr <= 16'h1fff && !is_port && state_r == iad_pkg::IAD_IDLE)
         |=> mem.data_rd && mem.data_addr == $past(ptr[12:0]);
   endproperty
   a_banked_addr: assert property (p_banked_addr) else $error("Banked address wrong.");

   property p_linear_gpr;
      @(posedge clk) disable iff (!rst_n)
      mem.data_rd && $past(region) == iad_pkg::IAD_RGN_LINEAR
         |-> mem.data_addr[6:0] >= 7'h20 && mem.data_addr[6:0] < 7'h70;
   endproperty
   a_linear_gpr: assert property (p_linear_gpr) else $error("Linear hit non-GENERAL_PURPOSE_RAM.");

   property p_zero_read;
      @(posedge clk) disable iff (!rst_n)
      zero_pend_r |=> rdata == 8'h00 && done;
   endproperty
   a_zero_read: assert property (p_zero_read) else $error("Zero answer wrong.");

   property p_flash_low;
      @(posedge clk) disable iff (!rst_n)
      state_r == iad_pkg::IAD_WAIT |=> ##1 rdata == $past(flash_rdata[7:0], 2);
   endproperty
   a_flash_low: assert property (p_flash_low) else $error("Flash byte wrong.");

   property p_flash_addr;
      @(posedge clk) disable iff (!rst_n)
      (req.rd && ptr[15] && state_r == iad_pkg::IAD_IDLE)
         |=> mem.flash_rd && mem.flash_addr == $past(ptr[14:0]);
   endproperty
   a_flash_addr: assert property (p_flash_addr) else $error("Flash address wrong.");

   c_flash: cover property (@(posedge clk) disable iff (!rst_n) state_r == iad_pkg::IAD_WAIT);
   c_linear: cover property (@(posedge clk) disable iff (!rst_n)
      req.rd && region == iad_pkg::IAD_RGN_LINEAR);
   c_port: cover property (@(posedge clk) disable iff (!rst_n) req.wr && is_port);

endmodule : iad_decoder

//--- bench/iad_mem_model.sv
// Behavioural data memory and program flash that answer the decoder's strobes.
module iad_mem_model (
   // Clock.
   input wire logic clk,
   // Strobes from the decoder.
   input wire iad_pkg::iad_mem_s mem,
   // Answers to the decoder.
   output logic [7:0] data_rdata,
   output logic [13:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] store_r [8192];
   logic dhold_r, fhold_r, tick_r;
   logic [7:0] dval_r;
   logic [13:0] fval_r;

   // Each flash word has upper bits set so that a lost truncation shows.
   function automatic logic [13:0] fword(input logic [14:0] a);
      return {6'h2b, a[7:0] ^ 8'h5a};
   endfunction : fword

   // Known fill so that reads of untouched bytes are predictable.
   initial
   begin
      for (int i = 0; i < 8192; i++) store_r[i] = i[7:0] ^ 8'ha5;
      dhold_r = 1'b0;
      fhold_r = 1'b0;
      tick_r = 1'b0;
   end

   // Writes land on the edge; answers are held for one cycle after the strobe.
   always @(posedge clk)
   begin
      if (mem.data_wr === 1'b1) store_r[mem.data_addr] <= mem.data_wdata;
      dhold_r <= (mem.data_rd === 1'b1);
      dval_r <= store_r[mem.data_addr];
      fhold_r <= (mem.flash_rd === 1'b1);
      fval_r <= fword(mem.flash_addr);
      tick_r <= ~tick_r;
   end

   // Outside the answer window the lines toggle every cycle instead of holding.
   assign data_rdata = (mem.data_rd === 1'b1) ? store_r[mem.data_addr] :
                       dhold_r ? dval_r : {8{tick_r}};
   assign flash_rdata = (mem.flash_rd === 1'b1) ? fword(mem.flash_addr) :
                        fhold_r ? fval_r : {14{tick_r}};
endmodule : iad_mem_model

//--- bench/tb.sv
// Self-checking testbench for the indirect address decoder.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst_n, done, stall, saw_dw, saw_dr, saw_st;
   logic [7:0] rdata, rdata_o, data_rdata;
   logic [13:0] flash_rdata;
   logic [12:0] addr_seen;
   logic [14:0] faddr_seen;
   iad_pkg::iad_req_s req;
   iad_pkg::iad_mem_s mem;
   int miscompares, checks_done, lat;

   iad_decoder iad_decoder_inst (.clk(clk), .rst_n(rst_n), .req(req), .done(done),
      .rdata(rdata_o), .stall(stall), .mem(mem), .data_rdata(data_rdata),
      .flash_rdata(flash_rdata));
   iad_mem_model iad_mem_model_inst (.clk(clk), .mem(mem), .data_rdata(data_rdata),
      .flash_rdata(flash_rdata));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One access: pulse the request, then watch strobes until done, then idle a cycle.
   task automatic op(input logic [15:0] ptr, input logic wr, input logic [7:0] wd);
      req = {ptr, ~wr, wr, wd};
      lat = 0;
      {saw_dw, saw_dr, saw_st, addr_seen, faddr_seen} = '0;
      do
      begin
         @(posedge clk);
         #1;
         if (lat == 0) {req.rd, req.wr} = 2'b00;
         lat++;
         if (mem.data_rd === 1'b1 || mem.data_wr === 1'b1) addr_seen = mem.data_addr;
         if (mem.data_wr === 1'b1) saw_dw = 1'b1;
         if (mem.data_rd === 1'b1) saw_dr = 1'b1;
         if (mem.flash_rd === 1'b1) faddr_seen = mem.flash_addr;
         if (stall === 1'b1) saw_st = 1'b1;
      end while (done !== 1'b1 && lat < 10);
      // The read byte stands for one cycle only, so it is caught with done.
      rdata = rdata_o;
      chk("done", 16'(done), 16'h0001);
      @(posedge clk);
      #1;
   endtask : op

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_banked();
      op(16'h0123, 1'b1, 8'h6e);
      chk("bank_wr_addr", 16'(addr_seen), 16'h0123);
      op(16'h0123, 1'b0, 8'h00);
      chk("bank_rd", 16'(rdata), 16'h006e);
      chk("bank_lat", 16'(lat), 16'h0002);
      op(16'h1fff, 1'b0, 8'h00);
      chk("bank_top", 16'(rdata), 16'h005a);
   endtask : t_banked

   task automatic t_port();
      op(16'h0081, 1'b1, 8'h11);
      chk("port_wr", 16'(saw_dw), 16'h0000);
      op(16'h0000, 1'b0, 8'h00);
      chk("port_rd", 16'(rdata), 16'h0000);
   endtask : t_port

   task automatic t_linear();
      op(16'h204f, 1'b1, 8'h77);
      chk("lin_last", 16'(addr_seen), 16'h006f);
      op(16'h2050, 1'b1, 8'h88);
      chk("lin_next", 16'(addr_seen), 16'h00a0);
      op(16'h006f, 1'b0, 8'h00);
      chk("lin_alias0", 16'(rdata), 16'h0077);
      op(16'h00a0, 1'b0, 8'h00);
      chk("lin_alias1", 16'(rdata), 16'h0088);
   endtask : t_linear

   // Unimplemented bank, past the linear end, and the last pointer below flash.
   task automatic t_unmapped();
      logic [15:0] ptrs [3] = '{16'h20a0, 16'h2ff0, 16'h7fff};
      foreach (ptrs[i])
      begin
         op(ptrs[i], 1'b1, 8'hc3);
         chk("unm_wr", 16'(saw_dw), 16'h0000);
         op(ptrs[i], 1'b0, 8'h00);
         chk("unm_rd", 16'(rdata), 16'h0000);
      end
   endtask : t_unmapped

   task automatic t_flash();
      op(16'h8005, 1'b0, 8'h00);
      chk("fl_addr", 16'(faddr_seen), 16'h0005);
      chk("fl_rd", 16'(rdata), 16'h005f);
      chk("fl_lat", 16'(lat), 16'h0003);
      chk("fl_stall", 16'(saw_st), 16'h0001);
      op(16'hfffe, 1'b0, 8'h00);
      chk("fl_top", 16'(faddr_seen), 16'h7ffe);
      chk("fl_top_rd", 16'(rdata), 16'h00a4);
      op(16'h8005, 1'b1, 8'h99);
      chk("fl_wr", 16'(saw_dw), 16'h0000);
      chk("fl_wr_lat", 16'(lat), 16'h0003);
      op(16'h8005, 1'b0, 8'h00);
      chk("fl_keep", 16'(rdata), 16'h005f);
   endtask : t_flash

   // ***************************************************************
   // Clock, reset, sequence and watchdog
   // ***************************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      miscompares = 0;
      checks_done = 0;
      rst_n = 1'b0;
      req = '0;
      repeat (8) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_banked();
      t_port();
      t_linear();
      t_unmapped();
      t_flash();
      close_out();
   end

   // 19 accesses of a few cycles each; this bound is far beyond that.
   initial
   begin
      #20000;
      miscompares++;
      close_out();
   end
endmodule : tb
